// [dsr_regs.svh]
// How it works
// RL1: velocity quick stop uses dedicated emergency ramp
// RL2: ramp rate is speed step over time step
// RL3: speed scaled by signed multiplier over divisor
// RL4: divisor is signed 32-bit, resets to one
// RL5: quick stop code 0: immediate stop, disable
// RL6: codes 1/2: slow/quick ramp, then disable
// RL7: codes 5/6: brake, hold quick stop energized
// RL8: shutdown code 0 coasts, 1 ramps down
// RL9: disable code 0 coasts, 1 ramps down
// RL10: reserved option codes are refused, value kept
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH
`define DSR_OFS_RAMP_SPEED 16'h604A
`define DSR_OFS_RAMP_TIME  16'h604B
`define DSR_OFS_SCALE_MUL  16'h604C
`define DSR_OFS_SCALE_DIV  16'h604D
`define DSR_OFS_QS_CODE    16'h605A
`define DSR_OFS_SD_CODE    16'h605B
`define DSR_OFS_DIS_CODE   16'h605C
`define DSR_OFS_STATUS     16'h6070
`define DSR_RST_RAMP_SPEED 32'h00001388
`define DSR_RST_RAMP_TIME  16'h0001
`define DSR_RST_SCALE_MUL  32'h00000001
`define DSR_RST_SCALE_DIV  32'h00000001
`define DSR_RST_QS_CODE    16'h0002
`define DSR_RST_SD_CODE    16'h0001
`define DSR_RST_DIS_CODE   16'h0001
`endif

// [dsr_pkg.sv]
package dsr_pkg;
  typedef enum logic [2:0]
  {
    DSR_IDLE  = 3'b000,
    DSR_BRAKE = 3'b001,
    DSR_COAST = 3'b010,
    DSR_HOLD  = 3'b011,
    DSR_DONE  = 3'b100
  } dsr_state_t;

  typedef enum logic [1:0]
  {
    DSR_EV_QS  = 2'b00,
    DSR_EV_SD  = 2'b01,
    DSR_EV_DIS = 2'b10
  } dsr_event_t;

  typedef enum logic [1:0]
  {
    DSR_RAMP_NONE  = 2'b00,
    DSR_RAMP_SLOW  = 2'b01,
    DSR_RAMP_QUICK = 2'b10
  } dsr_ramp_t;

  typedef struct packed
  {
    logic [31:0] ramp_speed_r;
    logic [15:0] ramp_time_r;
    logic [31:0] scale_mul_r;
    logic [31:0] scale_div_r;
    logic [15:0] qs_code_r;
    logic [15:0] sd_code_r;
    logic [15:0] dis_code_r;
    logic        reject_r;
    logic [31:0] rdata_r;
    dsr_state_t  state_r;
    dsr_event_t  event_r;
    dsr_ramp_t   ramp_r;
    logic        vel_mode_r;
    logic        energized_r;
  } dsr_st_t;
endpackage

// [dsr_top.sv]
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "dsr_regs.svh"
module dsr_top
  import dsr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // register port
  input  wire logic [15:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // power state machine requests, same clock
  input  wire logic        quickstop_req_in,
  input  wire logic        shutdown_req_in,
  input  wire logic        disable_req_in,
  input  wire logic        velocity_mode_in,
  input  wire logic        motor_stopped_in,
  input  wire logic        resume_in,
  // reaction
  output logic             brake_out,
  output logic             coast_out,
  output logic             energized_out,
  output logic [1:0]       ramp_sel_out,
  output logic             use_emergency_ramp_out,
  output logic             done_out,
  output logic             to_switch_on_disabled_out,
  output logic [31:0]      ramp_speed_step_out,
  output logic [15:0]      ramp_time_step_out,
  output logic [31:0]      speed_unit_mul_out,
  output logic [31:0]      speed_unit_div_out
);

  dsr_st_t s_r;
  dsr_st_t s_nxt;

  function automatic logic qs_ok(input logic [15:0] c);
    qs_ok = (c == 16'h0000) || (c == 16'h0001) || (c == 16'h0002)
         || (c == 16'h0005) || (c == 16'h0006);
  endfunction

  function automatic logic two_ok(input logic [15:0] c);
    two_ok = (c == 16'h0000) || (c == 16'h0001);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.reject_r = 1'b0;
    s_nxt.rdata_r = 32'h00000000;
    if (wr_in)
    begin
      unique case (addr_in)
        `DSR_OFS_RAMP_SPEED: s_nxt.ramp_speed_r = wdata_in;
        `DSR_OFS_RAMP_TIME:  s_nxt.ramp_time_r = wdata_in[15:0];
        `DSR_OFS_SCALE_MUL:  s_nxt.scale_mul_r = wdata_in;
        `DSR_OFS_SCALE_DIV:  s_nxt.scale_div_r = wdata_in;
        `DSR_OFS_QS_CODE:
        begin
          if (qs_ok(wdata_in[15:0])) s_nxt.qs_code_r = wdata_in[15:0]; // RL10
          else s_nxt.reject_r = 1'b1;
        end
        `DSR_OFS_SD_CODE:
        begin
          if (two_ok(wdata_in[15:0])) s_nxt.sd_code_r = wdata_in[15:0]; // RL10
          else s_nxt.reject_r = 1'b1;
        end
        `DSR_OFS_DIS_CODE:
        begin
          if (two_ok(wdata_in[15:0])) s_nxt.dis_code_r = wdata_in[15:0]; // RL10
          else s_nxt.reject_r = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_in)
    begin
      unique case (addr_in)
        `DSR_OFS_RAMP_SPEED: s_nxt.rdata_r = s_r.ramp_speed_r;
        `DSR_OFS_RAMP_TIME:  s_nxt.rdata_r = {16'h0000, s_r.ramp_time_r};
        `DSR_OFS_SCALE_MUL:  s_nxt.rdata_r = s_r.scale_mul_r;
        `DSR_OFS_SCALE_DIV:  s_nxt.rdata_r = s_r.scale_div_r;
        `DSR_OFS_QS_CODE:    s_nxt.rdata_r = {16'h0000, s_r.qs_code_r};
        `DSR_OFS_SD_CODE:    s_nxt.rdata_r = {16'h0000, s_r.sd_code_r};
        `DSR_OFS_DIS_CODE:   s_nxt.rdata_r = {16'h0000, s_r.dis_code_r};
        `DSR_OFS_STATUS:
          s_nxt.rdata_r = {24'h000000, s_r.energized_r, s_r.state_r,
                           s_r.ramp_r, s_r.event_r};
        default:             s_nxt.rdata_r = 32'h00000000;
      endcase
    end

    unique case (s_r.state_r)
      DSR_IDLE:
      begin
        s_nxt.energized_r = 1'b1;
        s_nxt.vel_mode_r  = velocity_mode_in;
        // quick stop has priority over the other two transitions
        if (quickstop_req_in)
        begin
          s_nxt.event_r = DSR_EV_QS;
          unique case (s_r.qs_code_r)
            16'h0000:
            begin
              s_nxt.ramp_r  = DSR_RAMP_NONE; // RL5
              s_nxt.state_r = DSR_DONE;
            end
            16'h0001, 16'h0005:
            begin
              s_nxt.ramp_r  = DSR_RAMP_SLOW; // RL6 RL7
              s_nxt.state_r = DSR_BRAKE;
            end
            default:
            begin
              s_nxt.ramp_r  = DSR_RAMP_QUICK; // RL6 RL7
              s_nxt.state_r = DSR_BRAKE;
            end
          endcase
        end
        else if (shutdown_req_in || disable_req_in)
        begin
          s_nxt.event_r = shutdown_req_in ? DSR_EV_SD : DSR_EV_DIS;
          if ((shutdown_req_in ? s_r.sd_code_r : s_r.dis_code_r) == 16'h0000)
          begin
            s_nxt.ramp_r      = DSR_RAMP_NONE; // RL8 RL9
            s_nxt.energized_r = 1'b0;
            s_nxt.state_r     = DSR_COAST;
          end
          else
          begin
            s_nxt.ramp_r  = DSR_RAMP_SLOW; // RL8 RL9
            s_nxt.state_r = DSR_BRAKE;
          end
        end
      end
      DSR_BRAKE:
      begin
        if (motor_stopped_in)
        begin
          if (s_r.event_r == DSR_EV_QS &&
              (s_r.qs_code_r == 16'h0005 || s_r.qs_code_r == 16'h0006))
            s_nxt.state_r = DSR_HOLD; // RL7
          else
            s_nxt.state_r = DSR_DONE;
        end
      end
      DSR_COAST:
      begin
        s_nxt.energized_r = 1'b0;
        s_nxt.state_r     = DSR_DONE;
      end
      DSR_HOLD:
      begin
        s_nxt.energized_r = 1'b1;
        s_nxt.ramp_r      = DSR_RAMP_NONE;
        if (resume_in)
          s_nxt.state_r = DSR_IDLE; // RL7
      end
      DSR_DONE:
      begin
        s_nxt.ramp_r      = DSR_RAMP_NONE;
        s_nxt.energized_r = 1'b0;
        s_nxt.state_r     = DSR_IDLE;
      end
      default: s_nxt.state_r = DSR_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_r              <= '0;
      s_r.ramp_speed_r <= `DSR_RST_RAMP_SPEED;
      s_r.ramp_time_r  <= `DSR_RST_RAMP_TIME;
      s_r.scale_mul_r  <= `DSR_RST_SCALE_MUL;
      s_r.scale_div_r  <= `DSR_RST_SCALE_DIV; // RL4
      s_r.qs_code_r    <= `DSR_RST_QS_CODE;
      s_r.sd_code_r    <= `DSR_RST_SD_CODE;
      s_r.dis_code_r   <= `DSR_RST_DIS_CODE;
      s_r.state_r      <= DSR_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // ramp and scale values go out raw; the divisions are done downstream
  // because a hardware divider here would cost far more than it saves
  assign rdata_out                 = s_r.rdata_r;
  assign brake_out                 = (s_r.state_r == DSR_BRAKE);
  assign coast_out                 = (s_r.state_r == DSR_COAST);
  assign energized_out             = s_r.energized_r;
  assign ramp_sel_out              = s_r.ramp_r;
  assign use_emergency_ramp_out    = brake_out && s_r.vel_mode_r &&
                                     (s_r.ramp_r == DSR_RAMP_QUICK); // RL1
  assign done_out                  = (s_r.state_r == DSR_DONE);
  assign to_switch_on_disabled_out = done_out && (s_r.event_r == DSR_EV_QS); // RL5 RL6
  assign ramp_speed_step_out       = s_r.ramp_speed_r; // RL2
  assign ramp_time_step_out        = s_r.ramp_time_r; // RL2
  assign speed_unit_mul_out        = s_r.scale_mul_r; // RL3
  assign speed_unit_div_out        = s_r.scale_div_r; // RL3

  ////////////////////////////////////////////////////////////////////////////
  // shared steps of the reactions; a reaction ends back in idle, except quick stop codes 5/6, which stay in hold until resume
  sequence s_finish;
    done_out ##1 (s_r.state_r == DSR_IDLE);
  endsequence

  sequence s_coast_finish;
    (coast_out && !energized_out) ##1 s_finish;
  endsequence

  // a coast request is shutdown or disable with option 0; quick stop wins
  sequence s_coast_req;
    (s_r.state_r == DSR_IDLE) && !quickstop_req_in
      && ((shutdown_req_in && s_r.sd_code_r == 16'h0000)
        || (!shutdown_req_in && disable_req_in && s_r.dis_code_r == 16'h0000));
  endsequence

  sequence s_ramp_req;
    (s_r.state_r == DSR_IDLE) && !quickstop_req_in && (shutdown_req_in || disable_req_in)
      && ((shutdown_req_in ? s_r.sd_code_r : s_r.dis_code_r) == 16'h0001);
  endsequence

  property p_reject;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `DSR_OFS_SD_CODE && !two_ok(wdata_in[15:0]))
      |=> $stable(s_r.sd_code_r);
  endproperty
  a_reject: assert property (p_reject) else $error("reserved code stored"); // RL10

  property p_qs_immediate;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_r.state_r == DSR_IDLE && quickstop_req_in && s_r.qs_code_r == 16'h0000)
      |=> s_finish;
  endproperty
  a_qs_immediate: assert property (p_qs_immediate) else $error("no immediate stop"); // RL5

  property p_qs_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    (brake_out && motor_stopped_in && s_r.event_r == DSR_EV_QS
      && s_r.qs_code_r == 16'h0006) |=> (s_r.state_r == DSR_HOLD) && energized_out;
  endproperty
  a_qs_hold: assert property (p_qs_hold) else $error("quick stop not held"); // RL7

  property p_emerg;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_r.state_r == DSR_IDLE && quickstop_req_in && velocity_mode_in
      && s_r.qs_code_r == 16'h0002) |=> use_emergency_ramp_out;
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency ramp not used"); // RL1

  property p_qs_slow;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_r.state_r == DSR_IDLE && quickstop_req_in
      && (s_r.qs_code_r == 16'h0001 || s_r.qs_code_r == 16'h0005))
      |=> brake_out && (ramp_sel_out == DSR_RAMP_SLOW) && !use_emergency_ramp_out;
  endproperty
  a_qs_slow: assert property (p_qs_slow) else $error("slow-down ramp not chosen"); // RL6 RL7

  // the quick ramp is the dedicated record when velocity mode is active
  property p_qs_quick;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_r.state_r == DSR_IDLE && quickstop_req_in
      && (s_r.qs_code_r == 16'h0002 || s_r.qs_code_r == 16'h0006))
      |=> brake_out && (ramp_sel_out == DSR_RAMP_QUICK) && energized_out;
  endproperty
  a_qs_quick: assert property (p_qs_quick) else $error("quick ramp not chosen"); // RL6 RL7

  // codes 1 and 2 leave through done towards switch on disabled
  property p_qs_release;
    @(posedge clk_in) disable iff (!rst_n_in)
    (brake_out && motor_stopped_in && s_r.event_r == DSR_EV_QS
      && (s_r.qs_code_r == 16'h0001 || s_r.qs_code_r == 16'h0002))
      |=> (done_out && to_switch_on_disabled_out) ##1 (s_r.state_r == DSR_IDLE);
  endproperty
  a_qs_release: assert property (p_qs_release) else $error("quick stop not released"); // RL6

  property p_coast;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_coast_req |=> s_coast_finish;
  endproperty
  a_coast: assert property (p_coast) else $error("drive not blocked"); // RL8 RL9

  property p_ramp_down;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_ramp_req |=> brake_out && (ramp_sel_out == DSR_RAMP_SLOW) && energized_out;
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("no slow-down braking"); // RL8 RL9

  // shutdown and disable finish in place, never towards switch on disabled
  property p_plain_end;
    @(posedge clk_in) disable iff (!rst_n_in)
    (brake_out && motor_stopped_in && s_r.event_r != DSR_EV_QS)
      |=> done_out && !to_switch_on_disabled_out;
  endproperty
  a_plain_end: assert property (p_plain_end) else $error("wrong end state"); // RL8 RL9

  // the hold keeps the motor energized until resume asks for operation
  property p_hold_stay;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_r.state_r == DSR_HOLD && !resume_in) |=> (s_r.state_r == DSR_HOLD) && energized_out;
  endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("hold left unasked"); // RL7

  property p_hold_resume;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_r.state_r == DSR_HOLD && resume_in) |=> (s_r.state_r == DSR_IDLE);
  endproperty
  a_hold_resume: assert property (p_hold_resume) else $error("no return to idle"); // RL7

  // refused writes leave the stored code and raise the refusal pulse
  property p_reject_qs;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `DSR_OFS_QS_CODE && !qs_ok(wdata_in[15:0]))
      |=> $stable(s_r.qs_code_r) && s_r.reject_r;
  endproperty
  a_reject_qs: assert property (p_reject_qs) else $error("reserved qs code stored"); // RL10

  property p_reject_dis;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `DSR_OFS_DIS_CODE && !two_ok(wdata_in[15:0]))
      |=> $stable(s_r.dis_code_r) && s_r.reject_r;
  endproperty
  a_reject_dis: assert property (p_reject_dis) else $error("reserved dis code stored"); // RL10

  // signed values pass unchanged; the sign only matters downstream
  property p_div_write;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `DSR_OFS_SCALE_DIV) |=> (speed_unit_div_out == $past(wdata_in));
  endproperty
  a_div_write: assert property (p_div_write) else $error("divisor not written"); // RL4

  property p_ramp_write;
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_in && addr_in == `DSR_OFS_RAMP_SPEED) |=> (ramp_speed_step_out == $past(wdata_in));
  endproperty
  a_ramp_write: assert property (p_ramp_write) else $error("speed step not written"); // RL2
endmodule

// [dsr_motor_model.sv]
`timescale 1ns/100ps
module dsr_motor_model
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // drive side
  input  wire logic       brake_in,
  input  wire logic [2:0] lag_in,
  output logic            stopped_out
);
  logic [2:0] cnt_r;
  // standstill only after lag_in + 1 braking cycles, so slow and prompt stops both occur
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r       <= 3'h0;
      stopped_out <= 1'b0;
    end
    else
    begin
      cnt_r       <= brake_in ? cnt_r + 3'h1 : 3'h0;
      stopped_out <= brake_in && (cnt_r >= lag_in);
    end
  end
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
`include "dsr_regs.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, qs = 0, sd = 0, dis = 0;
  logic vm = 0, stp, res = 0, brk, cst, eng, emr, dn_o, sod_o;
  logic [15:0] addr_in = 16'h0;
  logic [31:0] wdata_in = 32'h0, rdata_out, spd, mul, div, v;
  logic [15:0] tim;
  logic [1:0]  rsel;
  logic [2:0]  lag = 3'h0;
  int          err_total = 0, samples_checked = 0, i, s;
  logic [15:0] ofs [7] = '{`DSR_OFS_RAMP_SPEED, `DSR_OFS_RAMP_TIME, `DSR_OFS_SCALE_MUL,
    `DSR_OFS_SCALE_DIV, `DSR_OFS_QS_CODE, `DSR_OFS_SD_CODE, `DSR_OFS_DIS_CODE};
  logic [31:0] shd [7] = '{32'h1388, 32'h1, 32'h1, 32'h1, 32'h2, 32'h1, 32'h1};
  logic [15:0] qcodes [5] = '{16'h0, 16'h1, 16'h2, 16'h5, 16'h6};

  always #5 clk_in = ~clk_in;

  dsr_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .quickstop_req_in(qs),
    .shutdown_req_in(sd), .disable_req_in(dis), .velocity_mode_in(vm),
    .motor_stopped_in(stp), .resume_in(res), .brake_out(brk), .coast_out(cst),
    .energized_out(eng), .ramp_sel_out(rsel), .use_emergency_ramp_out(emr),
    .done_out(dn_o), .to_switch_on_disabled_out(sod_o), .ramp_speed_step_out(spd),
    .ramp_time_step_out(tim), .speed_unit_mul_out(mul), .speed_unit_div_out(div));

  dsr_motor_model motor (.clk_in(clk_in), .rst_n_in(rst_n_in), .brake_in(brk),
    .lag_in(lag), .stopped_out(stp));

  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a gap cycle after each strobe keeps one assignment per signal per step
  task wr(input logic [15:0] a, input logic [31:0] d);
    addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task rdx(input logic [15:0] a, input logic [31:0] e);
    addr_in <= a; rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 `CHK("rdata", e, rdata_out)
    @(posedge clk_in);
  endtask

  function logic [31:0] stored(input int k, input logic [31:0] d, input logic [31:0] old);
    if (k < 4)
      return (k == 1) ? {16'h0, d[15:0]} : d;
    if (k == 4)
      return (d[15:0] inside {0, 1, 2, 5, 6}) ? {16'h0, d[15:0]} : old;
    return (d[15:0] inside {0, 1}) ? {16'h0, d[15:0]} : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task react(input int ev, input logic [15:0] c);
    int n;
    logic br, co, dn, sd_seen, em;
    logic [1:0] rs, ers;
    br = 0; co = 0; dn = 0; sd_seen = 0; rs = 0; em = 0;
    ers = (c == 1 || c == 5) ? 2'h1 : (c == 2 || c == 6) ? 2'h2 : 2'h0;
    // code 2 always runs in velocity mode so the emergency ramp is exercised
    vm <= (c == 16'h2) || $urandom_range(1); lag <= $urandom;
    qs <= (ev == 0); sd <= (ev == 1); dis <= (ev == 2);
    @(posedge clk_in);
    qs <= 1'b0; sd <= 1'b0; dis <= 1'b0;
    for (n = 0; n < 40 && !dn; n++)
    begin
      #1 if (brk)
      begin
        br = 1; rs = rsel; em = emr;
      end
      if (cst) `CHK("coast_eng", 1'b0, eng)
      co |= cst; sd_seen |= sod_o; dn = dn_o;
      if (br && !brk && c > 4) dn = 1;
      @(posedge clk_in);
    end
    `CHK("done", 1'b1, dn)
    if (!dn) give_verdict();
    if (c != 0)
    begin
      `CHK("ramp", ers, rs)
      `CHK("emerg", vm && ers == 2'h2, em)
    end
    if (ev > 0) `CHK("coast", c == 0, co)
    `CHK("to_sod", ev == 0 && c < 3, sd_seen)
    if (c > 4)
    begin
      `CHK("energized", 1'b1, eng)
      rdx(`DSR_OFS_STATUS, 32'hB0);
      res <= 1'b1;
      @(posedge clk_in);
      res <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    s = $urandom(44);
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    `CHK("div_rst", 32'h1, div)
    for (i = 0; i < 7; i++) rdx(ofs[i], shd[i]);
    repeat (60)
    begin
      i = $urandom_range(6);
      v = (i < 4 || $urandom_range(3) == 0) ? $urandom : $urandom_range(7);
      wr(ofs[i], v);
      shd[i] = stored(i, v, shd[i]);
      rdx(ofs[i], shd[i]);
    end
    for (i = 4; i < 7; i++)
    begin
      wr(ofs[i], 32'h7);
      rdx(ofs[i], shd[i]);
    end
    `CHK("speed", shd[0], spd)
    `CHK("time", shd[1][15:0], tim)
    `CHK("mul", shd[2], mul)
    `CHK("div", shd[3], div)
    rdx(16'h6000, 32'h0);
    foreach (qcodes[k])
    begin
      wr(`DSR_OFS_QS_CODE, {16'h0, qcodes[k]});
      react(0, qcodes[k]);
    end
    for (i = 0; i < 4; i++)
    begin
      wr(ofs[5 + i / 2], i % 2);
      react(1 + i / 2, i % 2);
    end
    give_verdict();
  end
endmodule
